// ===== core/measure_extend.sv
// Measurement extend sequencer with control bus registers and interrupt
`timescale 1ns/1ps
`default_nettype none

module measure_extend (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control bus slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  output logic              irq_o,
  // Core request and reply
  input  wire logic         start_i,
  input  wire logic [63:0]  ctrl_ptr_i,
  input  wire logic [63:0]  chunk_ptr_i,
  input  wire logic         mode64_i,
  input  wire logic         prot_mode_i,
  input  wire logic [31:0]  ds_limit_i,
  input  wire logic [1:0]   cpl_i,
  output logic              done_o,
  output logic      [1:0]   fault_o,
  output logic      [63:0]  fault_addr_o,
  // Page map lookup
  output logic              map_req_o,
  output logic      [63:0]  map_addr_o,
  input  wire logic         map_ack_i,
  input  wire logic         map_in_epc_i,
  input  wire logic         map_valid_i,
  input  wire logic [7:0]   map_type_i,
  input  wire logic [63:0]  map_owner_i,
  input  wire logic [63:0]  map_lin_i,
  input  wire logic [63:0]  cp_base_i,
  input  wire logic         cp_init_i,
  // Conflict indications from other leaves
  input  wire logic         map_busy_i,
  input  wire logic         meas_busy_i,
  input  wire logic         init_busy_i,
  // Protected memory read
  output logic              mem_req_o,
  output logic      [63:0]  mem_addr_o,
  input  wire logic         mem_ack_i,
  input  wire logic [511:0] mem_data_i,
  // Hash update engine and update counter
  output logic              hash_valid_o,
  output logic      [511:0] hash_block_o,
  input  wire logic         hash_ready_i,
  output logic              ctr_inc_o,
  output logic      [2:0]   ctr_amt_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  measure_extend_pkg::state_t state_ff;
  logic [63:0]  cp_ptr_ff;
  logic [63:0]  ch_ptr_ff;
  logic         m64_ff;
  logic         prot_ff;
  logic [31:0]  lim_ff;
  logic [1:0]   cpl_ff;
  logic [63:0]  base_ff;
  logic         init_ff;
  logic [1:0]   blk_ff;
  logic [63:0]  offset_ff;
  logic [31:0]  upd_cnt_ff;
  logic         done_ff;
  logic [1:0]   flt_ff;
  logic [63:0]  flt_addr_ff;
  logic         map_req_ff;
  logic [63:0]  map_addr_ff;
  logic         mem_req_ff;
  logic [63:0]  mem_addr_ff;
  logic         hash_valid_ff;
  logic [511:0] hash_block_ff;
  logic         ctr_inc_ff;
  logic [2:0]   ctr_amt_ff;
  logic         en_ff;
  logic [2:0]   int_stat_ff;
  logic [2:0]   int_mask_ff;
  logic         irq_ff;
  logic         ack_ff;
  logic [31:0]  dat_ff;

  logic         cp_form;
  logic         cp_mis;
  logic         ch_form;
  logic         ch_mis;
  logic         chm_eval;
  logic         type_ok;
  logic [1:0]   chk_flt;
  logic [63:0]  chk_addr;
  logic [63:0]  nxt_offset;
  logic         bus_acc;
  logic [2:0]   evt;
  logic [2:0]   nxt_int_stat;

  // ----------------------------------------------------------------
  // Operand checks
  // ----------------------------------------------------------------
  operand_check #(.ALIGN_BITS(measure_extend_pkg::CP_ALIGN_BITS)) u_cp_check (
    .ptr_i       (cp_ptr_ff),
    .mode64_i    (m64_ff),
    .prot_mode_i (prot_ff),
    .limit_i     (lim_ff),
    .form_bad_o  (cp_form),
    .misalign_o  (cp_mis)
  );

  operand_check #(.ALIGN_BITS(measure_extend_pkg::CHUNK_ALIGN_BITS)) u_ch_check (
    .ptr_i       (ch_ptr_ff),
    .mode64_i    (m64_ff),
    .prot_mode_i (prot_ff),
    .limit_i     (lim_ff),
    .form_bad_o  (ch_form),
    .misalign_o  (ch_mis)
  );

  assign chm_eval = (state_ff == measure_extend_pkg::ST_CHMAP) & map_req_ff & map_ack_i;
  assign type_ok  = (map_type_i == measure_extend_pkg::TYPE_REGULAR)  |
                    (map_type_i == measure_extend_pkg::TYPE_THREAD)   |
                    (map_type_i == measure_extend_pkg::TYPE_SS_FIRST) |
                    (map_type_i == measure_extend_pkg::TYPE_SS_LATER);

  // Offset of the chunk inside the enclave
  assign nxt_offset = map_lin_i - base_ff +
                      {52'h0, ch_ptr_ff[measure_extend_pkg::PAGE_OFS_BITS-1:0]};

  // Fault decision per check phase, in the order the leaf must test
  always_comb begin
    chk_flt  = measure_extend_pkg::FLT_NONE;
    chk_addr = 64'h0;
    if (state_ff == measure_extend_pkg::ST_CHECK) begin
      // Disabled block, wrong privilege or bad operand form all fault
      if (!en_ff || cpl_ff != 2'h0 || cp_form || ch_form || cp_mis) begin
        chk_flt = measure_extend_pkg::FLT_GP;
      end
    end else if (state_ff == measure_extend_pkg::ST_CPMAP && map_ack_i) begin
      if (!map_in_epc_i) begin
        chk_flt  = measure_extend_pkg::FLT_PF;
        chk_addr = cp_ptr_ff;
      end else if (ch_mis) begin
        chk_flt = measure_extend_pkg::FLT_GP;
      end
    end else if (chm_eval) begin
      if (!map_in_epc_i || (!map_busy_i && (!map_valid_i || !type_ok))) begin
        chk_flt  = measure_extend_pkg::FLT_PF;
        chk_addr = ch_ptr_ff;
      end else if (map_busy_i || map_owner_i != cp_ptr_ff) begin
        chk_flt = measure_extend_pkg::FLT_GP;
      end else if (meas_busy_i || init_busy_i || init_ff) begin
        chk_flt = measure_extend_pkg::FLT_GP;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: checks, header, then four data blocks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff      <= measure_extend_pkg::ST_IDLE;
      cp_ptr_ff     <= 64'h0;
      ch_ptr_ff     <= 64'h0;
      m64_ff        <= 1'h0;
      prot_ff       <= 1'h0;
      lim_ff        <= 32'h0;
      cpl_ff        <= 2'h0;
      base_ff       <= 64'h0;
      init_ff       <= 1'h0;
      blk_ff        <= 2'h0;
      offset_ff     <= 64'h0;
      done_ff       <= 1'h0;
      flt_ff        <= measure_extend_pkg::FLT_NONE;
      flt_addr_ff   <= 64'h0;
      map_req_ff    <= 1'h0;
      map_addr_ff   <= 64'h0;
      mem_req_ff    <= 1'h0;
      mem_addr_ff   <= 64'h0;
      hash_valid_ff <= 1'h0;
      hash_block_ff <= 512'h0;
      ctr_inc_ff    <= 1'h0;
      ctr_amt_ff    <= 3'h0;
    end else begin
      done_ff    <= 1'h0;
      ctr_inc_ff <= 1'h0;
      if (chk_flt != measure_extend_pkg::FLT_NONE) begin
        // Any failed check ends the leaf before the hash is touched
        flt_ff      <= chk_flt;
        flt_addr_ff <= chk_addr;
        map_req_ff  <= 1'h0;
        state_ff    <= measure_extend_pkg::ST_REPLY;
      end else begin
        unique case (state_ff)
          measure_extend_pkg::ST_IDLE: begin
            if (start_i) begin
              cp_ptr_ff   <= ctrl_ptr_i;
              ch_ptr_ff   <= chunk_ptr_i;
              m64_ff      <= mode64_i;
              prot_ff     <= prot_mode_i;
              lim_ff      <= ds_limit_i;
              cpl_ff      <= cpl_i;
              flt_ff      <= measure_extend_pkg::FLT_NONE;
              flt_addr_ff <= 64'h0;
              state_ff    <= measure_extend_pkg::ST_CHECK;
            end
          end
          measure_extend_pkg::ST_CHECK: begin
            map_req_ff  <= 1'h1;
            map_addr_ff <= cp_ptr_ff;
            state_ff    <= measure_extend_pkg::ST_CPMAP;
          end
          measure_extend_pkg::ST_CPMAP: begin
            // Second lookup waits one idle cycle so each ack pairs with one request
            if (map_ack_i) begin
              base_ff     <= cp_base_i;
              init_ff     <= cp_init_i;
              map_req_ff  <= 1'h0;
              map_addr_ff <= ch_ptr_ff;
              state_ff    <= measure_extend_pkg::ST_CHMAP;
            end
          end
          measure_extend_pkg::ST_CHMAP: begin
            if (!map_req_ff) begin
              map_req_ff <= 1'h1;
            end else if (map_ack_i) begin
              map_req_ff    <= 1'h0;
              offset_ff     <= nxt_offset;
              hash_block_ff <= {384'h0, nxt_offset, measure_extend_pkg::HEADER_TAG};
              hash_valid_ff <= 1'h1;
              state_ff      <= measure_extend_pkg::ST_HDR;
            end
          end
          measure_extend_pkg::ST_HDR: begin
            if (hash_ready_i) begin
              hash_valid_ff <= 1'h0;
              ctr_inc_ff    <= 1'h1;
              ctr_amt_ff    <= measure_extend_pkg::HDR_COUNT;
              blk_ff        <= 2'h0;
              mem_req_ff    <= 1'h1;
              mem_addr_ff   <= ch_ptr_ff;
              state_ff      <= measure_extend_pkg::ST_RDBLK;
            end
          end
          measure_extend_pkg::ST_RDBLK: begin
            if (mem_ack_i) begin
              mem_req_ff    <= 1'h0;
              hash_block_ff <= mem_data_i;
              hash_valid_ff <= 1'h1;
              state_ff      <= measure_extend_pkg::ST_HSBLK;
            end
          end
          measure_extend_pkg::ST_HSBLK: begin
            if (hash_ready_i) begin
              hash_valid_ff <= 1'h0;
              if (blk_ff == measure_extend_pkg::LAST_BLOCK) begin
                ctr_inc_ff <= 1'h1;
                ctr_amt_ff <= measure_extend_pkg::DATA_COUNT;
                state_ff   <= measure_extend_pkg::ST_REPLY;
              end else begin
                // Blocks go out in ascending address order
                blk_ff      <= blk_ff + 2'h1;
                mem_req_ff  <= 1'h1;
                mem_addr_ff <= mem_addr_ff + measure_extend_pkg::BLOCK_BYTES;
                state_ff    <= measure_extend_pkg::ST_RDBLK;
              end
            end
          end
          measure_extend_pkg::ST_REPLY: begin
            done_ff  <= 1'h1;
            state_ff <= measure_extend_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Count of hash updates applied, visible to software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_cnt_ff <= 32'h0;
    end else if (ctr_inc_ff) begin
      upd_cnt_ff <= upd_cnt_ff + {29'h0, ctr_amt_ff};
    end
  end

  // ----------------------------------------------------------------
  // Control bus slave and interrupt
  // ----------------------------------------------------------------
  assign bus_acc = wb_cyc_i & wb_stb_i & ~ack_ff;

  // Events are taken as the reply goes out, fault class known by then
  assign evt[measure_extend_pkg::EVT_OK] = done_ff & (flt_ff == measure_extend_pkg::FLT_NONE);
  assign evt[measure_extend_pkg::EVT_GP] = done_ff & (flt_ff == measure_extend_pkg::FLT_GP);
  assign evt[measure_extend_pkg::EVT_PF] = done_ff & (flt_ff == measure_extend_pkg::FLT_PF);

  // Read clears, but an event in the same cycle survives the clear
  assign nxt_int_stat = ((bus_acc && !wb_we_i && wb_adr_i == measure_extend_pkg::OFS_INT_STAT) ?
                         3'h0 : int_stat_fff()) | evt;

  function automatic logic [2:0] int_stat_fff();
    return int_stat_ff;
  endfunction

  // Single-cycle answer to every access, unmapped ones read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'h0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= bus_acc;
      if (bus_acc && !wb_we_i) begin
        unique case (wb_adr_i)
          measure_extend_pkg::OFS_CTRL:      dat_ff <= {31'h0, en_ff};
          measure_extend_pkg::OFS_STATUS:    dat_ff <= {29'h0, flt_ff,
                                                        state_ff != measure_extend_pkg::ST_IDLE};
          measure_extend_pkg::OFS_INT_STAT:  dat_ff <= {29'h0, int_stat_ff};
          measure_extend_pkg::OFS_INT_MASK:  dat_ff <= {29'h0, int_mask_ff};
          measure_extend_pkg::OFS_UPD_COUNT: dat_ff <= upd_cnt_ff;
          measure_extend_pkg::OFS_OFFSET:    dat_ff <= offset_ff[31:0];
          default:                           dat_ff <= 32'h0;
        endcase
      end
    end
  end

  // Writable control fields, low byte lane only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff       <= measure_extend_pkg::CTRL_EN_RST;
      int_mask_ff <= measure_extend_pkg::INT_MASK_RST;
    end else if (bus_acc && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == measure_extend_pkg::OFS_CTRL) begin
        en_ff <= wb_dat_i[0];
      end
      if (wb_adr_i == measure_extend_pkg::OFS_INT_MASK) begin
        int_mask_ff <= wb_dat_i[2:0];
      end
    end
  end

  // Sticky status and level interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_ff <= 3'h0;
      irq_ff      <= 1'h0;
    end else begin
      int_stat_ff <= nxt_int_stat;
      irq_ff      <= |(nxt_int_stat & int_mask_ff);
    end
  end

  assign wb_dat_o     = dat_ff;
  assign wb_ack_o     = ack_ff;
  assign irq_o        = irq_ff;
  assign done_o       = done_ff;
  assign fault_o      = flt_ff;
  assign fault_addr_o = flt_addr_ff;
  assign map_req_o    = map_req_ff;
  assign map_addr_o   = map_addr_ff;
  assign mem_req_o    = mem_req_ff;
  assign mem_addr_o   = mem_addr_ff;
  assign hash_valid_o = hash_valid_ff;
  assign hash_block_o = hash_block_ff;
  assign ctr_inc_o    = ctr_inc_ff;
  assign ctr_amt_o    = ctr_amt_ff;

  // ----------------------------------------------------------------
  // Checks on the sequencer
  // ----------------------------------------------------------------
  AST_CP_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == measure_extend_pkg::ST_CHECK && cp_mis) |=>
    (state_ff == measure_extend_pkg::ST_REPLY && flt_ff == measure_extend_pkg::FLT_GP))
    else $error("misaligned control pointer not faulted");

  AST_CP_EPC: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == measure_extend_pkg::ST_CPMAP && map_ack_i && !map_in_epc_i) |=>
    (flt_ff == measure_extend_pkg::FLT_PF && flt_addr_ff == $past(cp_ptr_ff)))
    else $error("control pointer outside cache not page faulted");

  AST_CH_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == measure_extend_pkg::ST_CPMAP && map_ack_i && map_in_epc_i && ch_mis) |=>
    (flt_ff == measure_extend_pkg::FLT_GP) ##1 done_ff)
    else $error("misaligned chunk pointer not faulted");

  AST_CH_INVALID: assert property (@(posedge clk_i) disable iff (rst_i)
    (chm_eval && map_in_epc_i && !map_busy_i && !map_valid_i) |=>
    (flt_ff == measure_extend_pkg::FLT_PF && flt_addr_ff == ch_ptr_ff))
    else $error("invalid chunk page not page faulted");

  AST_OWNER: assert property (@(posedge clk_i) disable iff (rst_i)
    (chm_eval && map_in_epc_i && !map_busy_i && map_valid_i && type_ok &&
     map_owner_i != cp_ptr_ff) |=> (flt_ff == measure_extend_pkg::FLT_GP))
    else $error("foreign control page not faulted");

  AST_INITED: assert property (@(posedge clk_i) disable iff (rst_i)
    (chm_eval && init_ff) |=> (state_ff == measure_extend_pkg::ST_REPLY && !hash_valid_ff))
    else $error("initialized enclave was measured");

  AST_HEADER: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == measure_extend_pkg::ST_HDR) |->
    (hash_block_ff[63:0] == measure_extend_pkg::HEADER_TAG &&
     hash_block_ff[127:64] == offset_ff && hash_block_ff[511:128] == 384'h0))
    else $error("header block malformed");

  AST_HDR_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == measure_extend_pkg::ST_HDR && hash_ready_i) |=>
    (ctr_inc_ff && ctr_amt_ff == measure_extend_pkg::HDR_COUNT && mem_addr_ff == ch_ptr_ff))
    else $error("header step did not count one");

  AST_DATA_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == measure_extend_pkg::ST_HSBLK && hash_ready_i && blk_ff == 2'h3) |=>
    (ctr_inc_ff && ctr_amt_ff == measure_extend_pkg::DATA_COUNT) ##1 done_ff)
    else $error("data steps did not count four");

  AST_NO_EARLY_HASH: assert property (@(posedge clk_i) disable iff (rst_i)
    hash_valid_ff |-> (flt_ff == measure_extend_pkg::FLT_NONE && !done_ff))
    else $error("hash fed while a fault stands");

endmodule

`default_nettype wire

// ===== core/measure_extend_pkg.sv
// Constants, register map and state codes of the measurement extend block
package measure_extend_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the control bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_INT_STAT  = 8'h08;
  localparam logic [7:0] OFS_INT_MASK  = 8'h0c;
  localparam logic [7:0] OFS_UPD_COUNT = 8'h10;
  localparam logic [7:0] OFS_OFFSET    = 8'h14;

  // Reset values
  localparam logic       CTRL_EN_RST  = 1'h1;
  localparam logic [2:0] INT_MASK_RST = 3'h0;

  // Event bit positions, shared by status and mask registers
  localparam int EVT_OK = 0;
  localparam int EVT_GP = 1;
  localparam int EVT_PF = 2;

  // ----------------------------------------------------------------
  // Fault classes and operand checks
  // ----------------------------------------------------------------
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_GP   = 2'h1;
  localparam logic [1:0] FLT_PF   = 2'h2;

  localparam int CP_ALIGN_BITS    = 12;
  localparam int CHUNK_ALIGN_BITS = 8;
  localparam int PAGE_OFS_BITS    = 12;
  localparam int CANON_MSB        = 47;

  // Page type codes as reported by the page map
  localparam logic [7:0] TYPE_REGULAR  = 8'h01;
  localparam logic [7:0] TYPE_THREAD   = 8'h02;
  localparam logic [7:0] TYPE_SS_FIRST = 8'h03;
  localparam logic [7:0] TYPE_SS_LATER = 8'h04;

  // ----------------------------------------------------------------
  // Hash feed
  // ----------------------------------------------------------------
  localparam logic [63:0] HEADER_TAG  = 64'h00444e4554584545;
  localparam logic [63:0] BLOCK_BYTES = 64'h0000000000000040;
  localparam logic [1:0]  LAST_BLOCK  = 2'h3;
  localparam logic [2:0]  HDR_COUNT   = 3'h1;
  localparam logic [2:0]  DATA_COUNT  = 3'h4;

  // Sequencer states, Gray coded along the main path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CHECK = 3'h1,
    ST_CPMAP = 3'h3,
    ST_CHMAP = 3'h2,
    ST_HDR   = 3'h6,
    ST_RDBLK = 3'h7,
    ST_HSBLK = 3'h5,
    ST_REPLY = 3'h4
  } state_t;

endpackage

// ===== core/operand_check.sv
// Form, limit and alignment checks on one pointer operand
`timescale 1ns/1ps
`default_nettype none

module operand_check #(
  parameter int ALIGN_BITS = 8
) (
  // Operand and addressing mode
  input  wire logic [63:0] ptr_i,
  input  wire logic        mode64_i,
  input  wire logic        prot_mode_i,
  input  wire logic [31:0] limit_i,
  // Check results
  output logic             form_bad_o,
  output logic             misalign_o
);

  logic canon;

  // Canonical means all upper bits copy the highest implemented bit
  assign canon = (&ptr_i[63:measure_extend_pkg::CANON_MSB]) |
                 (~|ptr_i[63:measure_extend_pkg::CANON_MSB]);

  // Long mode checks form, legacy protected mode checks the limit
  assign form_bad_o = mode64_i ? ~canon :
                      (prot_mode_i & (ptr_i[31:0] > limit_i));

  assign misalign_o = |ptr_i[ALIGN_BITS-1:0];

endmodule

`default_nettype wire

// ===== dv/far_side_model.sv
// Far side model: page map and memory answers, hash engine acceptance
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  // Clock, reset and pace
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         slow_i,
  // Requests from the block
  input  wire logic         map_req_i,
  input  wire logic         mem_req_i,
  input  wire logic [63:0]  mem_addr_i,
  // Answers
  output logic              map_ack_o,
  output logic              mem_ack_o,
  output logic      [511:0] mem_data_o,
  output logic              hash_ready_o
);
  logic tog_ff;
  // Slow pace answers only every other cycle, stretching each handshake
  always_ff @(posedge clk_i) begin
    tog_ff    <= rst_i ? 1'b0 : ~tog_ff;
    map_ack_o <= ~rst_i & map_req_i & ~map_ack_o & (~slow_i | tog_ff);
    mem_ack_o <= ~rst_i & mem_req_i & ~mem_ack_o & (~slow_i | tog_ff);
  end
  // Data is only good with ack; inverted otherwise so stale data never matches
  assign mem_data_o   = mem_ack_o ? {8{mem_addr_i}} : ~{8{mem_addr_i}};
  assign hash_ready_o = ~slow_i | tog_ff;
endmodule
`default_nettype wire

// ===== dv/measure_extend_test.sv
// Self-checking bench for the measurement extend block
`timescale 1ns/1ps
`default_nettype none
module measure_extend_test;
  localparam logic [63:0] CP = 64'h0000000000900000;
  localparam logic [63:0] CH = 64'h0000000000805300;
  localparam logic [1:0]  OK = measure_extend_pkg::FLT_NONE;
  logic         clk_i = 1'b0, rst_i, cyc, wb_we_i, start_i, slow, mode64_i, prot_mode_i;
  logic         map_valid_i, map_busy_i, meas_busy_i, init_busy_i, cp_init_i;
  logic         wb_ack_o, irq_o, done_o, map_req_o, map_ack_i, map_in_epc_i, mem_req_o;
  logic         mem_ack_i, hash_valid_o, hash_ready_i, ctr_inc_o;
  logic [1:0]   cpl_i, fault_o;
  logic [2:0]   ctr_amt_o;
  logic [3:0]   wb_sel_i;
  logic [7:0]   wb_adr_i, map_type_i;
  logic [31:0]  wb_dat_i, wb_dat_o, ds_limit_i;
  logic [63:0]  ctrl_ptr_i, chunk_ptr_i, bad, map_owner_i, map_lin_i, cp_base_i;
  logic [63:0]  fault_addr_o, map_addr_o, mem_addr_o;
  logic [511:0] mem_data_i, hash_block_o;
  logic [511:0] blks[$];
  logic [2:0]   amts[$];
  int           failures = 0, num_checks = 0;

  measure_extend dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .start_i, .ctrl_ptr_i, .chunk_ptr_i,
    .mode64_i, .prot_mode_i, .ds_limit_i, .cpl_i, .done_o, .fault_o, .fault_addr_o,
    .map_req_o, .map_addr_o, .map_ack_i, .map_in_epc_i, .map_valid_i, .map_type_i,
    .map_owner_i, .map_lin_i, .cp_base_i, .cp_init_i, .map_busy_i, .meas_busy_i,
    .init_busy_i, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_data_i, .hash_valid_o,
    .hash_block_o, .hash_ready_i, .ctr_inc_o, .ctr_amt_o);
  far_side_model fsm (.clk_i, .rst_i, .slow_i(slow), .map_req_i(map_req_o),
    .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .map_ack_o(map_ack_i),
    .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i), .hash_ready_o(hash_ready_i));

  // Only the address named in bad lies outside the protected cache
  assign map_in_epc_i = (map_addr_o !== bad);

  // Record every accepted hash block and counter step
  always @(posedge clk_i) begin
    if (hash_valid_o && hash_ready_i) blks.push_back(hash_block_o);
    if (ctr_inc_o) amts.push_back(ctr_amt_o);
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task check(input string n, input logic [511:0] s, input logic [511:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %0h seen %0h", n, e, s);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc      <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
  endtask
  task defaults;
    ctrl_ptr_i <= CP;
    chunk_ptr_i <= CH;
    bad <= 64'h1;
    map_owner_i <= CP;
    map_lin_i <= 64'h403000;
    cp_base_i <= 64'h400000;
    {map_valid_i, map_busy_i, meas_busy_i, init_busy_i, cp_init_i} <= 5'h10;
    map_type_i <= 8'h1;
    {mode64_i, prot_mode_i, cpl_i} <= 4'hc;
    ds_limit_i <= 32'h1000;
  endtask
  // Start one leaf, wait for done, judge the reply and the hash traffic
  task run(input logic [1:0] ef, input logic [63:0] ea);
    blks.delete();
    amts.delete();
    @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    do @(posedge clk_i); while (done_o !== 1'b1);
    check("fault", fault_o, ef);
    check("fault_addr", fault_addr_o, ea);
    if (ef !== OK) check("no_hash", blks.size(), 0);
    else begin
      check("header", blks[0], {384'h0, 64'h3300, 64'h00444e4554584545});
      for (int i = 1; i < 5; i++) check("block", blks[i], {8{CH + 64'h40 * (i - 1)}});
      check("counter", {blks.size(), amts.size(), amts[0], amts[1]}, {32'h5, 32'h2, 6'h0c});
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_irq;
    logic [31:0] q;
    wb(1'b0, measure_extend_pkg::OFS_CTRL, 32'h0, q);
    check("ctrl_rst", q, 32'h1);
    wb(1'b0, 8'h20, 32'h0, q);
    check("unmapped", q, 32'h0);
    run(OK, 64'h0);
    check("irq_masked", irq_o, 1'b0);
    wb(1'b1, measure_extend_pkg::OFS_INT_MASK, 32'h7, q);
    @(posedge clk_i);
    check("irq_on", irq_o, 1'b1);
    wb(1'b0, measure_extend_pkg::OFS_INT_STAT, 32'h0, q);
    check("int_stat", q, 32'h1);
    @(posedge clk_i);
    check("irq_off", irq_o, 1'b0);
    wb(1'b1, measure_extend_pkg::OFS_CTRL, 32'h0, q);
    run(measure_extend_pkg::FLT_GP, 64'h0);
    wb(0, measure_extend_pkg::OFS_INT_STAT, 32'h0, q);
    check("int_stat_gp", q, 32'h2);
    wb(1'b1, measure_extend_pkg::OFS_CTRL, 32'h1, q);
  endtask
  // Remaining allowed page types, with a slow far side
  task t_types;
    logic [31:0] q;
    slow <= 1'b1;
    for (int t = 2; t < 5; t++) begin
      map_type_i <= 8'(t);
      run(OK, 64'h0);
    end
    slow <= 1'b0;
    wb(1'b0, measure_extend_pkg::OFS_UPD_COUNT, 32'h0, q);
    check("upd_count", q, 32'h14);
    wb(1'b0, measure_extend_pkg::OFS_OFFSET, 32'h0, q);
    check("offset", q, 32'h3300);
  endtask
  task t_faults;
    logic [1:0]  ef;
    logic [63:0] ea;
    for (int k = 0; k < 15; k++) begin
      defaults();
      case (k)
        0: ctrl_ptr_i <= CP + 64'h10;
        1: bad <= CP;
        2: chunk_ptr_i <= CH + 64'h10;
        3: bad <= CH;
        4: map_busy_i <= 1'b1;
        5: map_valid_i <= 1'b0;
        6: map_type_i <= 8'h0;
        7: map_type_i <= 8'h5;
        8: map_owner_i <= 64'h0;
        9: meas_busy_i <= 1'b1;
        10: init_busy_i <= 1'b1;
        11: cp_init_i <= 1'b1;
        12: chunk_ptr_i <= {16'h8000, CH[47:0]};
        13: mode64_i <= 1'b0;
        default: cpl_i <= 2'h1;
      endcase
      ef = (k inside {1, 3, 5, 6, 7}) ? measure_extend_pkg::FLT_PF : measure_extend_pkg::FLT_GP;
      ea = (k == 1) ? CP : ((k inside {3, 5, 6, 7}) ? CH : 64'h0);
      run(ef, ea);
    end
  endtask

  task end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial forever #12.5 clk_i = ~clk_i;
  // Watchdog: all scenarios need well under 2000 cycles
  initial begin
    #(25 * 5000);
    failures++;
    end_of_test();
  end
  initial begin
    {rst_i, cyc, wb_we_i, start_i, slow} = 5'h10;
    {wb_adr_i, wb_dat_i, wb_sel_i} = 44'h0;
    defaults();
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_irq();
    t_types();
    t_faults();
    end_of_test();
  end
endmodule
`default_nettype wire
